// ### logic/alu_pkg.sv
// package with constants, register map and types of the arithmetic/logic/bit unit
// Function
// - unsigned divide 16/8 and 32/16 with remainder
// - signed divide in the same two forms
// - compare subtracts, sets flags, keeps destination
// - negate replaces value with zero minus value
// - sign extend byte-to-word or word-to-long
// - zero extend byte-to-word or word-to-long
// - bitwise and into destination, any size
// - bitwise or into destination, any size
// - bitwise xor into destination, any size
// - complement inverts the destination bits that the operand size covers
// - arithmetic shifts keep sign on right shift
// - logical shifts fill vacated bit with zero
// - rotates feed leaving bit to other end
// - carry rotates include carry in the loop
// - bit number from immediate or register
// - bit set forces selected bit to one
// - bit clear forces selected bit to zero
// - bit invert toggles selected bit
// - bit test loads zero flag with inverse
// - carry and selected bit into carry
// - carry and inverted bit, immediate only
// - flag register holds negative, zero, overflow, carry
package alu_pkg;
  // bus address width and register byte offsets
  localparam int ADR_W = 5;
  localparam logic [4:0] OFS_DST = 5'h00;
  localparam logic [4:0] OFS_SRC = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_CCR = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  // reset value of data words
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // control word width; fields sit from bit 0 upward
  localparam int CTRL_W = 11;
  // status bit positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DZ_BIT = 1;
  // divider widths: dividend and divisor
  localparam int DIV_DW = 32;
  localparam int DIV_SW = 16;
  // operation codes
  typedef enum logic [4:0] {
    OP_DIVU = 5'h00, OP_DIVS = 5'h01, OP_CMP = 5'h02, OP_NEG = 5'h03,
    OP_SEXT = 5'h04, OP_ZEXT = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
    OP_XOR = 5'h08, OP_NOT = 5'h09, OP_ASL = 5'h0a, OP_ASR = 5'h0b,
    OP_LSL = 5'h0c, OP_LSR = 5'h0d, OP_ROL = 5'h0e, OP_ROR = 5'h0f,
    OP_RCL = 5'h10, OP_RCR = 5'h11, OP_SETB = 5'h12, OP_CLRB = 5'h13,
    OP_INVB = 5'h14, OP_TSTB = 5'h15, OP_BAND = 5'h16, OP_BANDN = 5'h17
  } alu_op_type;
  // operand sizes; code 3 acts as longword
  typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} alu_size_type;
  // control word: op [10:6], size [5:4], bit_reg [3], bit_imm [2:0]
  typedef struct packed {
    alu_op_type op;
    alu_size_type size;
    logic bit_reg;
    logic [2:0] bit_imm;
  } alu_ctrl_type;
  localparam alu_ctrl_type CTRL_RST = alu_ctrl_type'(11'h000);
  // condition flags, n in bit 3 down to c in bit 0
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } alu_ccr_type;
  localparam alu_ccr_type CCR_RST = alu_ccr_type'(4'h0);
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_EXEC = 3'h2, ST_DIV = 3'h4} alu_state_type;
  // whole state of the unit
  typedef struct packed {
    alu_state_type st;
    logic busy;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] dst;
    logic [31:0] src;
    alu_ctrl_type ctrl;
    alu_ccr_type condition_code_register;
    logic div_zero;
  } alu_regs_type;
  // one-cycle operation outcome
  typedef struct packed {
    logic [31:0] val;
    alu_ccr_type condition_code_register;
  } alu_res_type;
endpackage

// ### logic/alu_divider.sv
// sequential restoring divider for unsigned magnitudes
`timescale 1ns/1ps
module alu_divider #(
  parameter int DW = alu_pkg::DIV_DW,
  parameter int SW = alu_pkg::DIV_SW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [DW-1:0] dividend_i,
  input wire logic [SW-1:0] divisor_i,
  output logic done_o,
  output logic [DW-1:0] quot_o,
  output logic [SW-1:0] rem_o
);
  localparam int CW = $clog2(DW + 1);
  // divider state: one bit of quotient per cycle
  typedef struct packed {
    logic run;
    logic done;
    logic [CW-1:0] cnt;
    logic [DW-1:0] quot;
    logic [SW-1:0] rem;
    logic [SW-1:0] dvs;
  } alu_div_type;
  alu_div_type r;
  alu_div_type next_r;
  logic [SW:0] shifted; // partial remainder with next dividend bit
  logic [SW:0] trial; // partial remainder less divisor; top bit is borrow

  // one step: subtract if it fits, shift quotient bit in
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    shifted = {r.rem, r.quot[DW-1]};
    trial = shifted - {1'b0, r.dvs};
    if (start_i && !r.run) begin
      // load operands; the remainder starts empty
      next_r.run = 1'b1;
      next_r.cnt = CW'(DW);
      next_r.quot = dividend_i;
      next_r.rem = '0;
      next_r.dvs = divisor_i;
    end else if (r.run) begin
      if (!trial[SW]) begin
        next_r.rem = trial[SW-1:0];
        next_r.quot = {r.quot[DW-2:0], 1'b1};
      end else begin
        next_r.rem = shifted[SW-1:0];
        next_r.quot = {r.quot[DW-2:0], 1'b0};
      end
      next_r.cnt = r.cnt - CW'(1);
      // last step raises done for one cycle
      if (r.cnt == CW'(1)) begin
        next_r.run = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done_o = r.done;
  assign quot_o = r.quot;
  assign rem_o = r.rem;
endmodule

// ### logic/alu_unit.sv
// arithmetic, logic, shift and bit unit with a classic wishbone register slave
`timescale 1ns/1ps
module alu_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [alu_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic [3:0] ccr_o,
  output logic busy_o
);
  alu_pkg::alu_regs_type r; // current state
  alu_pkg::alu_regs_type next_r; // next state
  alu_pkg::alu_res_type res; // outcome of a one-cycle operation
  logic res_wr; // outcome is written back to the destination
  logic div_op; // current op is a divide
  logic div_sgn; // signed divide
  logic div_byte; // 16/8 form
  logic dvd_neg; // dividend is negative
  logic dvs_neg; // divisor is negative
  logic dvs_zero; // divisor is zero
  logic [31:0] dvd_mag; // dividend magnitude
  logic [15:0] dvs_mag; // divisor magnitude
  logic div_go; // start pulse to the divider
  logic div_done; // divider finished
  logic [31:0] div_quot; // unsigned quotient
  logic [15:0] div_rem; // unsigned remainder
  logic [31:0] q_fix; // quotient with sign applied
  logic [15:0] r_fix; // remainder with sign applied
  logic [2:0] bno; // selected bit number
  logic bsel; // value of the selected bit
  logic req; // bus cycle is open
  logic wr_now; // bus write commits this edge
  alu_pkg::alu_op_type op; // shorthand
  alu_pkg::alu_size_type sz; // shorthand

  // index of the sign bit for a size; code 3 acts as longword
  function automatic int hi_pos(input alu_pkg::alu_size_type s);
    return (s == alu_pkg::SZ_B) ? 7 : ((s == alu_pkg::SZ_W) ? 15 : 31);
  endfunction
  // mask of the bits a size covers
  function automatic logic [31:0] size_mask(input alu_pkg::alu_size_type s);
    return (s == alu_pkg::SZ_B) ? 32'h0000_00ff
         : ((s == alu_pkg::SZ_W) ? 32'h0000_ffff : 32'hffff_ffff);
  endfunction
  // value cut to a size
  function automatic logic [31:0] fit(input logic [31:0] v, input alu_pkg::alu_size_type s);
    return v & size_mask(s);
  endfunction
  // sign bit of a value at a size
  function automatic logic top(input logic [31:0] v, input alu_pkg::alu_size_type s);
    return v[hi_pos(s)];
  endfunction
  // new low part into old register, upper bits kept
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input alu_pkg::alu_size_type s);
    return (old & ~size_mask(s)) | (nw & size_mask(s));
  endfunction
  // value with its sign bit forced to b
  function automatic logic [31:0] set_top(input logic [31:0] v, input alu_pkg::alu_size_type s,
                                          input logic b);
    return (v & ~(32'h0000_0001 << hi_pos(s))) | (32'(b) << hi_pos(s));
  endfunction

  // n and z from a result, v cleared, c kept
  function automatic alu_pkg::alu_ccr_type nz_flags(input logic [31:0] v,
                                                    input alu_pkg::alu_size_type s,
                                                    input alu_pkg::alu_ccr_type f);
    alu_pkg::alu_ccr_type o;
    o = f;
    o.n = top(v, s);
    o.z = (fit(v, s) == 32'h0000_0000);
    o.v = 1'b0;
    return o;
  endfunction

  // a minus b at a size, with full flags
  function automatic alu_pkg::alu_res_type sub_op(input logic [31:0] a, input logic [31:0] b,
                                                  input alu_pkg::alu_size_type s,
                                                  input alu_pkg::alu_ccr_type f);
    alu_pkg::alu_res_type o;
    o.val = fit(a - b, s);
    o.condition_code_register = nz_flags(o.val, s, f);
    o.condition_code_register.c = (fit(a, s) < fit(b, s));
    o.condition_code_register.v = (top(a, s) ^ top(b, s)) & (top(a, s) ^ top(o.val, s));
    return o;
  endfunction

  // two's complement when neg is set
  function automatic logic [31:0] mag(input logic [31:0] v, input logic neg);
    return neg ? (32'h0000_0000 - v) : v;
  endfunction

  // byte-lane write under wishbone select
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] o;
    o = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) o[i*8 +: 8] = nw[i*8 +: 8];
    end
    return o;
  endfunction

  assign op = r.ctrl.op;
  assign sz = r.ctrl.size;
  assign req = wb_cyc_i & wb_stb_i;
  // write commits on the edge where the master sees ack
  assign wr_now = req & wb_we_i & r.ack;

  // bit number from register or immediate; inverted-carry and takes immediate only
  assign bno = (r.ctrl.bit_reg && op != alu_pkg::OP_BANDN) ? r.src[2:0]
                                                           : r.ctrl.bit_imm;
  assign bsel = r.dst[bno];

  // divide operand preparation
  assign div_op = (op == alu_pkg::OP_DIVU) || (op == alu_pkg::OP_DIVS);
  assign div_sgn = (op == alu_pkg::OP_DIVS);
  assign div_byte = (sz == alu_pkg::SZ_B);
  assign dvd_neg = div_sgn & (div_byte ? r.dst[15] : r.dst[31]);
  assign dvs_neg = div_sgn & (div_byte ? r.src[7] : r.src[15]);
  assign dvs_zero = div_byte ? (r.src[7:0] == 8'h00) : (r.src[15:0] == 16'h0000);
  assign dvd_mag = div_byte ? mag({{16{r.dst[15]}}, r.dst[15:0]}, dvd_neg) & 32'h0000_ffff
                            : mag(r.dst, dvd_neg);
  assign dvs_mag = div_byte ? 16'(mag({{24{r.src[7]}}, r.src[7:0]}, dvs_neg) & 32'h0000_00ff)
                            : 16'(mag({{16{r.src[15]}}, r.src[15:0]}, dvs_neg));
  assign div_go = (r.st == alu_pkg::ST_EXEC) & div_op & ~dvs_zero;
  // quotient negative when signs differ, remainder takes dividend sign
  assign q_fix = mag(div_quot, dvd_neg ^ dvs_neg);
  assign r_fix = 16'(mag({16'h0000, div_rem}, dvd_neg));

  // sequential magnitude divider
  alu_divider #(
    .DW(alu_pkg::DIV_DW),
    .SW(alu_pkg::DIV_SW)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(div_go),
    .dividend_i(dvd_mag),
    .divisor_i(dvs_mag),
    .done_o(div_done),
    .quot_o(div_quot),
    .rem_o(div_rem)
  );

  // one-cycle operations: result and flags from destination, source, flags
  always_comb begin
    res.val = r.dst;
    res.condition_code_register = r.condition_code_register;
    res_wr = 1'b1;
    unique case (op)
      alu_pkg::OP_CMP: begin
        res = sub_op(r.dst, r.src, sz, r.condition_code_register);
        res.val = r.dst;
        res_wr = 1'b0;
      end
      alu_pkg::OP_NEG: begin
        res = sub_op(32'h0000_0000, r.dst, sz, r.condition_code_register);
        res.val = merge(r.dst, res.val, sz);
      end
      alu_pkg::OP_SEXT: begin
        // byte size acts as the word form
        if (hi_pos(sz) == 31) begin
          res.val = {{16{r.dst[15]}}, r.dst[15:0]};
          res.condition_code_register = nz_flags(res.val, alu_pkg::SZ_L, r.condition_code_register);
        end else begin
          res.val = merge(r.dst, {16'h0000, {8{r.dst[7]}}, r.dst[7:0]}, alu_pkg::SZ_W);
          res.condition_code_register = nz_flags(res.val, alu_pkg::SZ_W, r.condition_code_register);
        end
      end
      alu_pkg::OP_ZEXT: begin
        if (hi_pos(sz) == 31) begin
          res.val = {16'h0000, r.dst[15:0]};
          res.condition_code_register = nz_flags(res.val, alu_pkg::SZ_L, r.condition_code_register);
        end else begin
          res.val = merge(r.dst, {24'h00_0000, r.dst[7:0]}, alu_pkg::SZ_W);
          res.condition_code_register = nz_flags(res.val, alu_pkg::SZ_W, r.condition_code_register);
        end
      end
      alu_pkg::OP_AND: begin
        res.val = merge(r.dst, r.dst & r.src, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
      end
      alu_pkg::OP_OR: begin
        res.val = merge(r.dst, r.dst | r.src, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
      end
      alu_pkg::OP_XOR: begin
        res.val = merge(r.dst, r.dst ^ r.src, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
      end
      alu_pkg::OP_NOT: begin
        res.val = merge(r.dst, ~r.dst, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
      end
      alu_pkg::OP_ASL, alu_pkg::OP_LSL: begin
        // left shift by one, zero enters, sign bit leaves to carry
        res.val = merge(r.dst, r.dst << 1, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
        res.condition_code_register.c = top(r.dst, sz);
        if (op == alu_pkg::OP_ASL) begin
          res.condition_code_register.v = top(r.dst, sz) ^ top(res.val, sz);
        end
      end
      alu_pkg::OP_ASR: begin
        // sign bit stays in place
        res.val = merge(r.dst, set_top(fit(r.dst, sz) >> 1, sz, top(r.dst, sz)), sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
        res.condition_code_register.c = r.dst[0];
      end
      alu_pkg::OP_LSR: begin
        res.val = merge(r.dst, fit(r.dst, sz) >> 1, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
        res.condition_code_register.c = r.dst[0];
      end
      alu_pkg::OP_ROL: begin
        res.val = merge(r.dst, {r.dst[30:0], top(r.dst, sz)}, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
        res.condition_code_register.c = top(r.dst, sz);
      end
      alu_pkg::OP_ROR: begin
        res.val = merge(r.dst, set_top(fit(r.dst, sz) >> 1, sz, r.dst[0]), sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
        res.condition_code_register.c = r.dst[0];
      end
      alu_pkg::OP_RCL: begin
        // old carry enters bit 0, sign bit goes to carry
        res.val = merge(r.dst, {r.dst[30:0], r.condition_code_register.c}, sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
        res.condition_code_register.c = top(r.dst, sz);
      end
      alu_pkg::OP_RCR: begin
        res.val = merge(r.dst, set_top(fit(r.dst, sz) >> 1, sz, r.condition_code_register.c), sz);
        res.condition_code_register = nz_flags(res.val, sz, r.condition_code_register);
        res.condition_code_register.c = r.dst[0];
      end
      alu_pkg::OP_SETB: begin
        res.val = r.dst | (32'h0000_0001 << bno);
      end
      alu_pkg::OP_CLRB: begin
        res.val = r.dst & ~(32'h0000_0001 << bno);
      end
      alu_pkg::OP_INVB: begin
        res.val = r.dst ^ (32'h0000_0001 << bno);
      end
      alu_pkg::OP_TSTB: begin
        res.condition_code_register.z = ~bsel;
        res_wr = 1'b0;
      end
      alu_pkg::OP_BAND: begin
        res.condition_code_register.c = r.condition_code_register.c & bsel;
        res_wr = 1'b0;
      end
      alu_pkg::OP_BANDN: begin
        res.condition_code_register.c = r.condition_code_register.c & ~bsel;
        res_wr = 1'b0;
      end
      default: begin
        // divides and unused codes leave everything as it is
        res_wr = 1'b0;
      end
    endcase
  end

  // bus slave, register writes and operation sequencer
  always_comb begin
    next_r = r;
    // ack for one cycle per request, read data caught with it
    next_r.ack = req & ~r.ack;
    next_r.rdat = alu_pkg::RST_WORD;
    unique case ({wb_adr_i[alu_pkg::ADR_W-1:2], 2'b00})
      alu_pkg::OFS_DST: next_r.rdat = r.dst;
      alu_pkg::OFS_SRC: next_r.rdat = r.src;
      alu_pkg::OFS_CTRL: next_r.rdat = {21'h00_0000, r.ctrl};
      alu_pkg::OFS_CCR: next_r.rdat = {28'h000_0000, r.condition_code_register};
      alu_pkg::OFS_STAT: begin
        next_r.rdat[alu_pkg::STAT_BUSY_BIT] = r.busy;
        next_r.rdat[alu_pkg::STAT_DZ_BIT] = r.div_zero;
      end
      default: next_r.rdat = alu_pkg::RST_WORD;
    endcase
    // writes reach registers only while idle
    if (wr_now && r.st == alu_pkg::ST_IDLE) begin
      unique case ({wb_adr_i[alu_pkg::ADR_W-1:2], 2'b00})
        alu_pkg::OFS_DST: next_r.dst = lanes(r.dst, wb_dat_i, wb_sel_i);
        alu_pkg::OFS_SRC: next_r.src = lanes(r.src, wb_dat_i, wb_sel_i);
        alu_pkg::OFS_CCR: begin
          if (wb_sel_i[0]) begin
            next_r.condition_code_register = alu_pkg::alu_ccr_type'(wb_dat_i[3:0]);
          end
        end
        alu_pkg::OFS_CTRL: begin
          // control write launches the operation
          next_r.ctrl = alu_pkg::alu_ctrl_type'(alu_pkg::CTRL_W'(lanes({21'h00_0000, r.ctrl},
                                                                       wb_dat_i, wb_sel_i)));
          next_r.st = alu_pkg::ST_EXEC;
          next_r.busy = 1'b1;
          next_r.div_zero = 1'b0;
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
    // sequencer
    unique case (r.st)
      alu_pkg::ST_IDLE: begin
        // waiting for a control write
      end
      alu_pkg::ST_EXEC: begin
        if (div_op && dvs_zero) begin
          // zero divisor: destination kept, error flagged
          next_r.condition_code_register.z = 1'b1;
          next_r.condition_code_register.n = div_byte ? r.src[7] : r.src[15];
          next_r.div_zero = 1'b1;
          next_r.st = alu_pkg::ST_IDLE;
          next_r.busy = 1'b0;
        end else if (div_op) begin
          next_r.st = alu_pkg::ST_DIV;
        end else begin
          next_r.condition_code_register = res.condition_code_register;
          if (res_wr) begin
            next_r.dst = res.val;
          end
          next_r.st = alu_pkg::ST_IDLE;
          next_r.busy = 1'b0;
        end
      end
      alu_pkg::ST_DIV: begin
        if (div_done) begin
          // remainder above quotient in the destination
          if (div_byte) begin
            next_r.dst = merge(r.dst, {16'h0000, r_fix[7:0], q_fix[7:0]}, alu_pkg::SZ_W);
            next_r.condition_code_register.n = div_sgn ? q_fix[7] : r.src[7];
          end else begin
            next_r.dst = {r_fix, q_fix[15:0]};
            next_r.condition_code_register.n = div_sgn ? q_fix[15] : r.src[15];
          end
          next_r.condition_code_register.z = 1'b0;
          next_r.st = alu_pkg::ST_IDLE;
          next_r.busy = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '{st: alu_pkg::ST_IDLE, busy: 1'b0, ack: 1'b0, rdat: alu_pkg::RST_WORD,
             dst: alu_pkg::RST_WORD, src: alu_pkg::RST_WORD, ctrl: alu_pkg::CTRL_RST,
             condition_code_register: alu_pkg::CCR_RST, div_zero: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign ccr_o = r.condition_code_register;
  assign busy_o = r.busy;
endmodule

// ### sim/alu_unit_checker.sv
// concurrent checks on the ports of the arithmetic, logic, shift and bit unit
`timescale 1ns/1ps
module alu_unit_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [alu_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0] ccr_o,
  input wire logic busy_o
);
  logic busy_q; // busy one cycle ago
  logic rst_q; // reset one cycle ago, masks stale history
  logic [4:0] lop; // op code of the last started operation
  logic [3:0] lccr; // flags when that operation started
  wire commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[4:2] == 3'h2 && !busy_o;
  wire fin = busy_q && !busy_o && !rst_q;
  // remember the operation and the flags it started from
  always_ff @(posedge clk_i) begin
    busy_q <= busy_o;
    rst_q <= rst_i;
    if (commit) begin
      lop <= wb_dat_i[10:6];
      lccr <= ccr_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_short_op; commit && wb_dat_i[10:7] != 4'h0 |=> busy_o ##1 !busy_o; endproperty
  property p_div_len; commit && wb_dat_i[10:7] == 4'h0 |=> busy_o ##[1:40] !busy_o; endproperty
  property p_bit_keep; fin && lop inside {5'h12, 5'h13, 5'h14} |-> ccr_o == lccr; endproperty
  property p_test_z; fin && lop == 5'h15 |-> {ccr_o[3], ccr_o[1:0]} == {lccr[3], lccr[1:0]};
  endproperty
  property p_carry_and; fin && lop inside {5'h16, 5'h17} |->
    ccr_o[3:1] == lccr[3:1] && !(ccr_o[0] && !lccr[0]); endproperty
  property p_logic_v; fin && lop inside {[5'h04:5'h09]} |-> !ccr_o[1] && ccr_o[0] == lccr[0];
  endproperty
  property p_div_keep; fin && lop inside {5'h00, 5'h01} |-> ccr_o[1:0] == lccr[1:0]; endproperty
  property p_flag_hold; !rst_q && $changed(ccr_o) |->
    $past(busy_o) || $past(wb_ack_o && wb_we_i && wb_adr_i[4:2] == 3'h3); endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_short_op: assert property (p_short_op) else $error("busy not one cycle");
  a_div_len: assert property (p_div_len) else $error("divide too long");
  a_bit_keep: assert property (p_bit_keep) else $error("bit op changed flags");
  a_test_z: assert property (p_test_z) else $error("bit test touched n v c");
  a_carry_and: assert property (p_carry_and) else $error("carry and wrong");
  a_logic_v: assert property (p_logic_v) else $error("overflow or carry wrong");
  a_div_keep: assert property (p_div_keep) else $error("divide changed v c");
  a_flag_hold: assert property (p_flag_hold) else $error("flags changed idle");
  c_div: cover property (commit && wb_dat_i[10:7] == 4'h0);
  c_test: cover property (fin && lop == 5'h15);
  c_ccr_wr: cover property (wb_ack_o && wb_we_i && wb_adr_i[4:2] == 3'h3);
endmodule
bind alu_unit alu_unit_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .ccr_o(ccr_o),
  .busy_o(busy_o));

// ### sim/alu_unit_tb.sv
// register-level testbench of the arithmetic, logic, shift and bit unit
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module alu_unit_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0; // bus request lines
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic ack;
  logic [31:0] dat_o;
  logic [3:0] ccr_o;
  logic busy_o;
  logic [31:0] r; // last read word
  int n_mismatch = 0;
  int checks_done = 0;
  alu_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dat_o),
    .ccr_o(ccr_o), .busy_o(busy_o));
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v,
    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, 4'hf, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 4'hf, q);
  endtask
  // poll status until the unit is idle
  task automatic idle();
    do rd(5'h10, r); while (r[0] !== 1'b0);
  endtask
  // load flags and operands, start op, compare result and flags
  task automatic t(input logic [4:0] op, input logic [5:0] md, input logic [3:0] ci,
    input logic [31:0] d, s, ed, input logic [3:0] ec);
    wr(5'h0c, {28'h0, ci});
    wr(5'h00, d);
    wr(5'h04, s);
    wr(5'h08, {21'h0, op, md});
    idle();
    rd(5'h00, r);
    `CHK(r, ed)
    `CHK(ccr_o, ec)
  endtask
  task automatic end_sim();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // all words and an unmapped one read zero
    for (int i = 0; i < 6; i++) begin
      rd(5'(i * 4), r);
      `CHK(r, 32'h0)
    end
    bus(1'b1, 5'h0c, 32'hf, 4'he, r);
    rd(5'h0c, r);
    `CHK(r, 32'h0)
    // writes refused while a divide runs
    wr(5'h00, 32'h64);
    wr(5'h04, 32'h7);
    wr(5'h08, 32'h0);
    rd(5'h10, r);
    `CHK(r[0], 1'b1)
    `CHK(busy_o, 1'b1)
    wr(5'h00, 32'h0);
    idle();
    rd(5'h00, r);
    `CHK(r, 32'h20e)
    t(5'h00, 6'h00, 4'h3, 32'h64, 32'h7, 32'h20e, 4'h3);
    t(5'h00, 6'h10, 4'h0, 32'h10000, 32'h3, 32'h15555, 4'h0);
    t(5'h01, 6'h00, 4'h0, 32'hff9c, 32'h7, 32'hfef2, 4'h8);
    t(5'h01, 6'h10, 4'h1, 32'hffffff9c, 32'hfff9, 32'hfffe000e, 4'h1);
    t(5'h02, 6'h00, 4'h0, 32'h5, 32'h7, 32'h5, 4'h9);
    t(5'h02, 6'h10, 4'h0, 32'h8000, 32'h1, 32'h8000, 4'h2);
    t(5'h03, 6'h10, 4'h0, 32'haaaa0001, 32'h0, 32'haaaaffff, 4'h9);
    t(5'h04, 6'h10, 4'h3, 32'h12340080, 32'h0, 32'h1234ff80, 4'h9);
    t(5'h04, 6'h20, 4'h0, 32'h8001, 32'h0, 32'hffff8001, 4'h8);
    t(5'h05, 6'h20, 4'h2, 32'hffff0000, 32'h0, 32'h0, 4'h4);
    t(5'h06, 6'h20, 4'h3, 32'hf0f0f0f0, 32'h0ff00ff0, 32'h00f000f0, 4'h1);
    t(5'h07, 6'h00, 4'h0, 32'h12345600, 32'h81, 32'h12345681, 4'h8);
    t(5'h08, 6'h10, 4'h0, 32'h5555, 32'h5555, 32'h0, 4'h4);
    t(5'h09, 6'h20, 4'h0, 32'hffff, 32'h0, 32'hffff0000, 4'h8);
    t(5'h0a, 6'h00, 4'h0, 32'h40, 32'h0, 32'h80, 4'ha);
    t(5'h0b, 6'h00, 4'h0, 32'h81, 32'h0, 32'hc0, 4'h9);
    t(5'h0c, 6'h20, 4'h0, 32'h80000001, 32'h0, 32'h2, 4'h1);
    t(5'h0d, 6'h10, 4'h0, 32'h8001, 32'h0, 32'h4000, 4'h1);
    t(5'h0e, 6'h00, 4'h0, 32'h81, 32'h0, 32'h3, 4'h1);
    t(5'h0f, 6'h20, 4'h0, 32'h1, 32'h0, 32'h80000000, 4'h9);
    t(5'h10, 6'h00, 4'h0, 32'h80, 32'h0, 32'h0, 4'h5);
    t(5'h11, 6'h10, 4'h1, 32'h0, 32'h0, 32'h8000, 4'h8);
    t(5'h12, 6'h07, 4'h5, 32'h12340000, 32'h0, 32'h12340080, 4'h5);
    t(5'h12, 6'h08, 4'h0, 32'h0, 32'hfffffffb, 32'h8, 4'h0);
    t(5'h13, 6'h00, 4'ha, 32'hff, 32'h0, 32'hfe, 4'ha);
    t(5'h14, 6'h08, 4'h0, 32'h20, 32'h5, 32'h0, 4'h0);
    t(5'h15, 6'h02, 4'hb, 32'hfb, 32'h0, 32'hfb, 4'hf);
    t(5'h16, 6'h08, 4'hf, 32'h0, 32'h4, 32'h0, 4'he);
    t(5'h17, 6'h0b, 4'h1, 32'h1, 32'h0, 32'h1, 4'h1);
    t(5'h17, 6'h00, 4'h1, 32'h1, 32'h0, 32'h1, 4'h0);
    // zero divisor keeps the operand and flags it in status
    t(5'h00, 6'h00, 4'h0, 32'h1234, 32'h0, 32'h1234, 4'h4);
    rd(5'h10, r);
    `CHK(r, 32'h2)
    end_sim();
  end
endmodule
